/* File: bench/attr_mode_blink_control_tb_top.sv */
// self-checking testbench for the attribute mode and blink control block
`timescale 1ns/1ps
`include "attr_mode_map.svh"
module attr_mode_blink_control_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, vsync = 1'b0, pix_valid = 1'b0;
    logic [7:0] char_code = 8'h00, attr_byte = 8'h00;
    logic glyph_dot = 1'b0, ninth_col = 1'b0, eighth_dot = 1'b0;
    logic [3:0] fb_pixel = 4'h0, pal_index;
    logic pal_valid, blink_phase;
    int n_errors = 0, tests_run = 0;
    // clock enable starts high; one step drives it low to check that the frame counter freezes
    attr_mode_blink_control attr_mode_blink_control_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .vsync(vsync), .pix_valid(pix_valid),
        .char_code(char_code), .attr_byte(attr_byte), .glyph_dot(glyph_dot), .ninth_col(ninth_col),
        .eighth_dot(eighth_dot), .fb_pixel(fb_pixel), .pal_index(pal_index), .pal_valid(pal_valid),
        .blink_phase(blink_phase));
    always #2.5 pclk = ~pclk;
    task automatic stop_test();
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_errors++;
            stop_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // one pixel, result checked one edge later
    task automatic pix(input logic [7:0] c, input logic [7:0] at, input logic g, input logic n9,
                       input logic e8, input logic [3:0] fb, input logic [3:0] exp);
        @(posedge pclk);
        char_code <= c;
        attr_byte <= at;
        glyph_dot <= g;
        ninth_col <= n9;
        eighth_dot <= e8;
        fb_pixel <= fb;
        pix_valid <= 1'b1;
        @(posedge pclk);
        pix_valid <= 1'b0;
        #1;
        chk("pal_index", {28'h0, pal_index}, {28'h0, exp});
        chk("pal_valid", {31'h0, pal_valid}, 32'h1);
    endtask
    task automatic frames(input int k);
        repeat (k) begin
            @(posedge pclk);
            vsync <= 1'b1;
            @(posedge pclk);
            vsync <= 1'b0;
        end
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `AMC_OFF_MODE, 32'h0); chk("mode reset", rd, 32'h0);
        apb(1'b0, `AMC_OFF_PLANE, 32'h0); chk("plane reset", rd, 32'hF);
        apb(1'b0, `AMC_OFF_STATUS, 32'h0); chk("status reset", rd, 32'h0);
        apb(1'b0, 12'h00C, 32'h0); chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, `AMC_OFF_MODE, 32'hFF);
        apb(1'b0, `AMC_OFF_MODE, 32'h0); chk("mode mask", rd, 32'hEF);
        // text, no blink: bit 7 is background intensity
        apb(1'b1, `AMC_OFF_MODE, 32'h00);
        pix(8'h41, 8'hF1, 1'b0, 1'b0, 1'b0, 4'h3, 4'hF);
        pix(8'h41, 8'hF1, 1'b1, 1'b0, 1'b0, 4'h3, 4'h1);
        pix(8'hC5, 8'h21, 1'b0, 1'b1, 1'b1, 4'h0, 4'h2);
        // mono text behaves like color text
        apb(1'b1, `AMC_OFF_MODE, 32'h02);
        pix(8'h41, 8'hF1, 1'b0, 1'b0, 1'b0, 4'h3, 4'hF);
        pix(8'h41, 8'hF1, 1'b1, 1'b0, 1'b0, 4'h3, 4'h1);
        apb(1'b1, `AMC_OFF_MODE, 32'h04);
        pix(8'hC0, 8'h21, 1'b0, 1'b1, 1'b1, 4'h0, 4'h1);
        pix(8'hDF, 8'h21, 1'b0, 1'b1, 1'b1, 4'h0, 4'h1);
        pix(8'hE0, 8'h21, 1'b0, 1'b1, 1'b1, 4'h0, 4'h2);
        pix(8'hBF, 8'h21, 1'b0, 1'b1, 1'b1, 4'h0, 4'h2);
        pix(8'hC5, 8'h21, 1'b0, 1'b1, 1'b0, 4'h0, 4'h2);
        // text blink, phase starts in the off half
        apb(1'b1, `AMC_OFF_MODE, 32'h08);
        pix(8'h41, 8'hF1, 1'b1, 1'b0, 1'b0, 4'h0, 4'h7);
        pix(8'h41, 8'h71, 1'b1, 1'b0, 1'b0, 4'h0, 4'h1);
        pix(8'h41, 8'hF1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h7);
        frames(15);
        apb(1'b0, `AMC_OFF_STATUS, 32'h0); chk("status 15", rd, 32'h00F);
        frames(1);
        apb(1'b0, `AMC_OFF_STATUS, 32'h0); chk("status 16", rd, 32'h110);
        chk("blink_phase", {31'h0, blink_phase}, 32'h1);
        pix(8'h41, 8'hF1, 1'b1, 1'b0, 1'b0, 4'h0, 4'h1);
        // graphics during the on half
        apb(1'b1, `AMC_OFF_MODE, 32'h0B);
        pix(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 4'h5, 4'h5);
        apb(1'b1, `AMC_OFF_MODE, 32'h09);
        pix(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 4'hD, 4'hD);
        pix(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 4'h5, 4'hD);
        frames(16);
        apb(1'b0, `AMC_OFF_STATUS, 32'h0); chk("status wrap", rd, 32'h000);
        // ce low freezes the frame counter
        @(posedge pclk);
        ce <= 1'b0;
        frames(2);
        @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, `AMC_OFF_STATUS, 32'h0); chk("status frozen", rd, 32'h000);
        // graphics during the off half
        pix(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 4'hD, 4'h5);
        pix(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 4'h5, 4'hD);
        apb(1'b1, `AMC_OFF_PLANE, 32'h7);
        pix(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 4'hF, 4'hF);
        apb(1'b1, `AMC_OFF_MODE, 32'h0B);
        pix(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 4'hF, 4'h0);
        apb(1'b1, `AMC_OFF_MODE, 32'h01);
        pix(8'h00, 8'hFF, 1'b1, 1'b0, 1'b0, 4'hA, 4'h2);
        apb(1'b1, `AMC_OFF_MODE, 32'h05);
        pix(8'hC5, 8'h21, 1'b0, 1'b1, 1'b1, 4'h3, 4'h3);
        // a second reset clears the counter and the mode register
        frames(3);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `AMC_OFF_STATUS, 32'h0); chk("status after reset", rd, 32'h000);
        apb(1'b0, `AMC_OFF_MODE, 32'h0); chk("mode after reset", rd, 32'h000);
        stop_test();
    end
endmodule

/* File: rtl/attr_mode_blink_control.sv */
// attribute controller mode select, ninth dot and blink logic with apb registers
// Notes on behaviour
// [R1] mode bit 0 expands text attributes
// [R2] mode bit 1 feeds pixels, graphics blinking; the code takes graphics from mode bit 0
// [R3] lgr off: ninth dot is background
// [R4] lgr on: copy eighth dot, line chars
// [R5] software clears lgr for plain fonts
// [R6] no blink: attribute bit 7 intensity
// [R7] blink: attribute bit 7 blinks, vsync/32
// [R8] mono graphics blink toggles every pixel
// [R9] color blink: bit 3 toggles or forced
// [R10] blink applied after plane masking
// [R11] blink waveform has fifty percent duty
// [R12] low two bits select mono, graphics
// [R13] vsync counter, phase flips per 16
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`include "attr_mode_map.svh"
module attr_mode_blink_control #(
    parameter int CNT_W = `AMC_CNT_W
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // frame timing from the crt controller
    input wire logic vsync,
    // pixel stream in
    input wire logic pix_valid,
    input wire logic [7:0] char_code,
    input wire logic [7:0] attr_byte,
    input wire logic glyph_dot,
    input wire logic ninth_col,
    input wire logic eighth_dot,
    input wire logic [3:0] fb_pixel,
    // palette input out
    output logic [3:0] pal_index,
    output logic pal_valid,
    output logic blink_phase
);

    attr_mode_pkg::state_s st_reg;
    attr_mode_pkg::state_s st_next;
    attr_mode_pkg::disp_mode_e mode;
    logic blink_en;
    logic lgr_en;
    logic phase;
    logic [3:0] masked;
    logic [3:0] bg_idx;
    logic dot_on;

    // line graphics characters sit in one contiguous code range
    // a compare pair is cheaper than a table; both ends are inclusive
    function automatic logic is_line_gfx(input logic [7:0] code);
        is_line_gfx = (code >= `AMC_LGR_FIRST) && (code <= `AMC_LGR_LAST);
    endfunction

    // decoded control fields
    assign mode = attr_mode_pkg::disp_mode_e'(st_reg.mode_ctl[`AMC_BIT_MONO:`AMC_BIT_GFX]); // R12
    assign blink_en = st_reg.mode_ctl[`AMC_BIT_BLINK];
    assign lgr_en = st_reg.mode_ctl[`AMC_BIT_LGR];
    // msb of a 32-frame counter is high for exactly half the period
    // the counter width fixes the period: 2**CNT_W frames, half on, half off
    assign phase = st_reg.blink_cnt[CNT_W-1]; // R11
    assign masked = fb_pixel & st_reg.plane_en; // R10

    // next state: register bus, blink counter, pixel path
    always_comb begin
        st_next = st_reg;
        bg_idx = 4'h0;
        dot_on = 1'b0;
        // vsync rising edge advances the frame counter
        // vsync is taken as synchronous; a raw pin would need two flops first
        st_next.vs_prev = vsync;
        if (vsync && !st_reg.vs_prev) begin
            st_next.blink_cnt = st_reg.blink_cnt + 1'b1; // R13
        end
        // limitation: ce low at the completing edge still shows pready to the
        // master, but the frozen state drops the write; keep ce high per transfer
        // apb: answer in the first access cycle, no wait state
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h0000_0000;
            // status is read only: writes to it are dropped without an error
            unique case (paddr)
                `AMC_OFF_MODE: begin
                    st_next.prdata[7:0] = st_reg.mode_ctl;
                end
                `AMC_OFF_PLANE: begin
                    st_next.prdata[3:0] = st_reg.plane_en;
                end
                `AMC_OFF_STATUS: begin
                    st_next.prdata[CNT_W-1:0] = st_reg.blink_cnt;
                    st_next.prdata[8] = phase;
                end
                default: begin
                    st_next.pslverr = 1'b1;
                end
            endcase
        end else if (psel && penable && st_reg.pready) begin
            // pslverr drops with pready, so it never stands on its own
            // writes land only at the completing edge
            if (pwrite && paddr == `AMC_OFF_MODE) begin
                st_next.mode_ctl = pwdata[7:0] & `AMC_MODE_WMASK;
            end
            if (pwrite && paddr == `AMC_OFF_PLANE) begin
                st_next.plane_en = pwdata[3:0];
            end
        end
        // pixel path; output holds between valid pixels
        // pal_index is left alone between pixels so the palette sees no glitch
        st_next.pal_valid = pix_valid;
        if (pix_valid) begin
            unique case (mode)
                attr_mode_pkg::MODE_TEXT_COLOR,
                attr_mode_pkg::MODE_TEXT_MONO: begin
                    // bit 7 is either intensity or blink
                    if (blink_en) begin
                        bg_idx = {1'b0, attr_byte[6:4]}; // R7
                    end else begin
                        bg_idx = attr_byte[7:4]; // R6
                    end
                    if (ninth_col) begin
                        // ninth dot only copies for line graphics codes
                        dot_on = lgr_en && is_line_gfx(char_code) && eighth_dot; // R3 R4
                    end else begin
                        dot_on = glyph_dot;
                    end
                    // blinking characters show background in the off half
                    if (blink_en && attr_byte[7] && !phase) begin
                        dot_on = 1'b0; // R7
                    end
                    st_next.pal_index = dot_on ? attr_byte[3:0] : bg_idx; // R1
                end
                attr_mode_pkg::MODE_GFX_MONO: begin
                    // lgr is ignored here, whatever software left in it
                    // plane 3 off does not matter here: the whole pixel blanks
                    st_next.pal_index = masked; // R2 R5
                    if (blink_en && !phase) begin
                        st_next.pal_index = 4'h0; // R8
                    end
                end
                attr_mode_pkg::MODE_GFX_COLOR: begin
                    st_next.pal_index = masked; // R2
                    if (blink_en) begin
                        // bit 3 after masking decides, so plane 3 off stops blink
                        st_next.pal_index[3] = masked[3] ? phase : 1'b1; // R9 R10
                    end
                end
            endcase
        end
    end

    // single state register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // constants only here; the struct copy takes over once running
            st_reg.mode_ctl <= `AMC_MODE_RST;
            st_reg.plane_en <= `AMC_PLANE_RST;
            st_reg.vs_prev <= 1'b0;
            st_reg.blink_cnt <= '0; // R13
            st_reg.pready <= 1'b0;
            st_reg.pslverr <= 1'b0;
            st_reg.prdata <= 32'h0000_0000;
            st_reg.pal_index <= 4'h0;
            st_reg.pal_valid <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign prdata = st_reg.prdata;
    assign pal_index = st_reg.pal_index;
    assign pal_valid = st_reg.pal_valid;
    // blink_phase is the counter msb, a flop like the rest
    assign blink_phase = phase;

    // checks on the pixel path and blink timing
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // every pixel check carries ce in its antecedent: a frozen edge updates
    // nothing, so a look one edge ahead would otherwise see stale outputs

    // helpers: text mode flag and the vsync rising edge, qualified by ce
    logic txt;
    logic vs_rise;
    assign txt = !st_reg.mode_ctl[`AMC_BIT_GFX];
    assign vs_rise = ce && vsync && !st_reg.vs_prev;

    // text foreground dots take the low attribute nibble
    text_fg_a: assert property (ce && pix_valid && txt && !ninth_col && glyph_dot // R1
        && !(blink_en && attr_byte[7]) |=> pal_index == $past(attr_byte[3:0]))
        else $error("text foreground not expanded");

    // without blink the masked pixel goes straight to the palette
    gfx_pixel_a: assert property (ce && pix_valid && !txt && !blink_en // R2
        |=> pal_index == $past(masked))
        else $error("graphics pixel not passed");

    // lgr off: the ninth column always shows background
    ninth_bg_a: assert property (ce && pix_valid && txt && ninth_col && !lgr_en // R3
        |=> pal_index == ($past(blink_en) ? {1'b0, $past(attr_byte[6:4])} : $past(attr_byte[7:4])))
        else $error("ninth dot not background");

    // lgr on: box drawing codes stretch the eighth dot across the gap
    ninth_copy_a: assert property (ce && pix_valid && txt && ninth_col && lgr_en // R4
        && is_line_gfx(char_code) && eighth_dot && !blink_en
        |=> pal_index == $past(attr_byte[3:0]))
        else $error("ninth dot not copied");

    // bit 7 widens the background to sixteen colors when blink is off
    intensity_bg_a: assert property (ce && pix_valid && txt && !blink_en // R6
        && !ninth_col && !glyph_dot |=> pal_index == $past(attr_byte[7:4]))
        else $error("bit 7 not used as intensity");

    // off half: blinking characters fall back to the background
    char_blink_a: assert property (ce && pix_valid && txt && blink_en && attr_byte[7] // R7
        && !phase |=> pal_index == {1'b0, $past(attr_byte[6:4])})
        else $error("blinking character shown in off phase");

    // mono graphics blanks the whole screen in the off half
    mono_blink_a: assert property (ce && pix_valid && mode == attr_mode_pkg::MODE_GFX_MONO // R8
        && blink_en && !phase |=> pal_index == 4'h0)
        else $error("mono graphics pixel not blanked");

    // color graphics pins bit 3 high on pixels that do not blink
    color_bit3_a: assert property (ce && pix_valid && mode == attr_mode_pkg::MODE_GFX_COLOR // R9
        && blink_en && !masked[3] |=> pal_index[3] && pal_index[2:0] == $past(masked[2:0]))
        else $error("color bit 3 not forced");

    // the phase flips on every sixteenth frame edge
    phase_flip_a: assert property (vs_rise && st_reg.blink_cnt[CNT_W-2:0] == '1 // R11
        |=> blink_phase != $past(blink_phase))
        else $error("blink phase did not flip after sixteen frames");

    // nothing but a frame edge may move the phase
    phase_hold_a: assert property (!vs_rise |=> $stable(blink_phase)) // R13
        else $error("blink phase moved without vsync");

    // the slave never waits beyond the first access cycle
    apb_answer_a: assert property (ce && psel && !penable ##1 ce && psel && penable
        |-> pready)
        else $error("apb access not answered at once");

    // on half: blinking characters show their foreground again
    char_show_a: assert property (ce && pix_valid && txt && blink_en && attr_byte[7] && phase // R7
        && !ninth_col && glyph_dot |=> pal_index == $past(attr_byte[3:0]))
        else $error("blinking character hidden in on phase");

    // with blink on, the background loses its intensity bit
    bg_blink_a: assert property (ce && pix_valid && txt && blink_en && !ninth_col && !glyph_dot // R7
        |=> pal_index == {1'b0, $past(attr_byte[6:4])})
        else $error("background intensity kept while blinking");

    // codes outside the line graphics range keep a background ninth dot
    ninth_plain_a: assert property (ce && pix_valid && txt && ninth_col && lgr_en // R4
        && !is_line_gfx(char_code) && !blink_en |=> pal_index == $past(attr_byte[7:4]))
        else $error("ninth dot copied for a plain code");

    // a blank eighth dot leaves the ninth dot blank as well
    ninth_blank_a: assert property (ce && pix_valid && txt && ninth_col && lgr_en // R4
        && !eighth_dot && !blink_en |=> pal_index == $past(attr_byte[7:4]))
        else $error("ninth dot set without an eighth dot");

    // on half: mono graphics shows the masked pixel unchanged
    mono_show_a: assert property (ce && pix_valid && mode == attr_mode_pkg::MODE_GFX_MONO // R8
        && blink_en && phase |=> pal_index == $past(masked))
        else $error("mono graphics pixel blanked in on phase");

    // blinking color pixels carry the phase in bit 3, the rest untouched
    color_toggle_a: assert property (ce && pix_valid && mode == attr_mode_pkg::MODE_GFX_COLOR // R9
        && blink_en && masked[3] |=> pal_index[3] == $past(phase) && pal_index[2:0] == $past(masked[2:0]))
        else $error("color bit 3 does not follow the blink phase");

    // the frame counter steps by one per vsync edge and wraps at the top
    cnt_step_a: assert property (vs_rise |=> st_reg.blink_cnt == $past(st_reg.blink_cnt) + 1'b1) // R13
        else $error("frame counter did not step");

    // without a frame edge the counter holds, whatever else happens
    cnt_idle_a: assert property (!vs_rise |=> $stable(st_reg.blink_cnt)) // R13
        else $error("frame counter moved without vsync");

    // pal_valid is pix_valid one enabled edge later
    pal_valid_a: assert property (ce |=> pal_valid == $past(pix_valid)) // R1 R2
        else $error("pal_valid does not follow pix_valid");

    text_blink_c: cover property (ce && pix_valid && txt && blink_en && attr_byte[7] && !phase);
    mono_blink_c: cover property (ce && pix_valid && mode == attr_mode_pkg::MODE_GFX_MONO && blink_en);
    color_blink_c: cover property (ce && pix_valid && mode == attr_mode_pkg::MODE_GFX_COLOR && blink_en
        && masked[3]);
    lgr_copy_c: cover property (ce && pix_valid && txt && ninth_col && lgr_en && is_line_gfx(char_code));
    mono_text_c: cover property (ce && pix_valid && mode == attr_mode_pkg::MODE_TEXT_MONO);

endmodule

/* File: rtl/attr_mode_map.svh */
// register offsets, field positions, reset values and blink timing
`ifndef ATTR_MODE_MAP_SVH
`define ATTR_MODE_MAP_SVH
`define AMC_OFF_MODE 12'h000
`define AMC_OFF_PLANE 12'h004
`define AMC_OFF_STATUS 12'h008
`define AMC_BIT_GFX 0
`define AMC_BIT_MONO 1
`define AMC_BIT_LGR 2
`define AMC_BIT_BLINK 3
`define AMC_MODE_WMASK 8'hEF
`define AMC_MODE_RST 8'h00
`define AMC_PLANE_RST 4'hF
`define AMC_LGR_FIRST 8'hC0
`define AMC_LGR_LAST 8'hDF
`define AMC_BLINK_FRAMES 32
`define AMC_CNT_W 5
`endif

/* File: rtl/attr_mode_pkg.sv */
// types for the attribute mode and blink control block
package attr_mode_pkg;
    typedef enum logic [1:0] {
        MODE_TEXT_COLOR = 2'b00,
        MODE_GFX_COLOR = 2'b01,
        MODE_TEXT_MONO = 2'b10,
        MODE_GFX_MONO = 2'b11
    } disp_mode_e;
    typedef struct packed {
        logic [7:0] mode_ctl;
        logic [3:0] plane_en;
        logic vs_prev;
        logic [4:0] blink_cnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [3:0] pal_index;
        logic pal_valid;
    } state_s;
endpackage
